// [asp_pkg.sv]
// Shared constants for the nine-bit capable asynchronous serial port
package asp_pkg;
   // Register locations on the special-function register port
   localparam logic [7:0] CTRL_OFFSET = 8'h98;
   localparam logic [7:0] DATA_OFFSET = 8'h99;
   // Control register field positions
   localparam int         FMT_BIT     = 7;
   localparam int         UNUSED_BIT  = 6;
   localparam int         CHECK_BIT   = 5;
   localparam int         RXEN_BIT    = 4;
   localparam int         TX9_BIT     = 3;
   localparam int         RX9_BIT     = 2;
   localparam int         TDONE_BIT   = 1;
   localparam int         RDONE_BIT   = 0;
   // Reset values
   localparam logic [7:0] CTRL_RESET  = 8'h40;
   localparam logic [7:0] DATA_RESET  = 8'h00;
   // Timer reloads after its top count, 256-reload states in all
   localparam logic [7:0] TIMER_TOP   = 8'hFF;
   // Bit times per frame
   localparam logic [3:0] FRAME_BITS8 = 4'hA;
   localparam logic [3:0] FRAME_BITS9 = 4'hB;
   // Sample index of the last sampled bit after the start bit
   localparam logic [3:0] LAST_IDX8   = 4'h8;
   localparam logic [3:0] LAST_IDX9   = 4'h9;
endpackage : asp_pkg

// [asp_link_if.sv]
// Serial link between the port and the remote serial partner
interface asp_link_if;
   logic dev_to_peer;
   logic peer_to_dev;
   modport device (output dev_to_peer, input peer_to_dev);
   modport peer   (input dev_to_peer, output peer_to_dev);
endinterface : asp_link_if

// [asp_device.sv]
// Serial port end: control/data registers, baud timers, transmit, receive
//
// Contract
// - Bit rate is timer clock/(256-reload)/2
// - Control bit 7 selects 8 or 9-bit frames
// - 8-bit frame: start, 8 data LSB first, stop
// - 9-bit frame adds ninth bit from control
// - Data write loads and starts transmission
// - Transmit-done set at start of stop bit
// - Receive only while receive-enable bit is set
// - 8-bit accept: done clear, stop checked if enabled
// - 9-bit: ninth bit stored, stop ignored
// - 9-bit accept: done clear, ninth checked if enabled
// - Accept stores byte, ninth field, sets done
// - Overrun keeps first byte, drops later data
// - Receive-done set when stop bit sampled
// - One interrupt from either done flag
// - Only software clears the done flags
// - Ninth transmit bit field used only in 9-bit
// - Control bit 6 reads one, ignores writes
// - Master sends addresses ninth=1, data ninth=0
// - Matched slave clears check bit, later sets
// - Receive timer reloaded on start detect
// - Data location: read receive, write transmit
module asp_device (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Special-function register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Baud timer controls, tick is one pulse per timer input clock
   input  wire logic       baud_timer_input_clock,
   input  wire logic       baud_timer_run,
   input  wire logic [7:0] baud_reload_byte,
   // Interrupt
   input  wire logic       irq_enable,
   output logic            irq,
   // Serial link
   asp_link_if.device      link
);
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} asp_tx_type;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100
   } asp_rx_type;

   // Control fields
   logic       fmt_q, check_q, rxen_q, tx9_q, rx9_q, tdone_q, rdone_q;
   logic       tdone_d, rdone_d;
   logic [7:0] rx_latch_q;
   logic [7:0] reg_rdata_q;
   logic       irq_q;
   // Timers
   logic [7:0] tx_tmr_q, rx_tmr_q;
   logic       tx_half_q, rx_phase_q;
   // Transmitter
   asp_tx_type tx_st_q;
   logic [10:0] tx_sh_q;
   logic [3:0] tx_cnt_q;
   logic       txd_q;
   // Receiver
   asp_rx_type rx_st_q;
   logic [8:0] rx_bits_q;
   logic [3:0] rx_idx_q;
   logic       rxd_prev_q;

   // Register access decode
   wire        wr_ctrl  = reg_wr && (reg_addr == asp_pkg::CTRL_OFFSET);
   wire        wr_data  = reg_wr && (reg_addr == asp_pkg::DATA_OFFSET);
   wire [7:0]  ctrl_val = {fmt_q, 1'b1, check_q, rxen_q,
                           tx9_q, rx9_q, tdone_q, rdone_q};
   wire [7:0]  rd_mux   = (reg_addr == asp_pkg::CTRL_OFFSET) ? ctrl_val :
                          (reg_addr == asp_pkg::DATA_OFFSET) ? rx_latch_q :
                          8'h00;

   // Timer overflow: 256-reload input ticks between overflows
   wire tick   = baud_timer_input_clock && baud_timer_run;
   wire tx_ovf = tick && (tx_tmr_q == asp_pkg::TIMER_TOP);
   wire rx_ovf = tick && (rx_tmr_q == asp_pkg::TIMER_TOP);
   // Overflows halved into bit boundaries
   wire tx_baud = tx_ovf && tx_half_q;

   // Receive pin events
   wire rxd      = link.peer_to_dev;
   wire start_ev = rxen_q && (rx_st_q == RX_IDLE)
                   && rxd_prev_q && !rxd;
   // Sample on every other overflow, first one half a bit in
   wire rx_samp  = rx_ovf && !rx_phase_q;
   wire [3:0] last_idx = fmt_q ? asp_pkg::LAST_IDX9 : asp_pkg::LAST_IDX8;
   wire       at_last  = (rx_st_q == RX_DATA) && rx_samp
                         && (rx_idx_q == last_idx);
   // 8-bit checks the stop bit, 9-bit checks the ninth and ignores stop
   wire       ninth_in = fmt_q ? rx_bits_q[8] : rxd;
   wire       accept   = at_last && rxen_q && !rdone_q
                         && (!check_q || ninth_in);

   // Transmit frame start and start of stop bit
   wire tx_start = wr_data && (tx_st_q == TX_IDLE);
   wire tx_stop  = (tx_st_q == TX_SEND) && tx_baud
                   && (tx_cnt_q == 4'h1);

   // Flags: hardware set wins over a software clear in the same cycle
   assign tdone_d = tx_stop
                    || (wr_ctrl ? reg_wdata[asp_pkg::TDONE_BIT]
                                : tdone_q);
   assign rdone_d = accept
                    || (wr_ctrl ? reg_wdata[asp_pkg::RDONE_BIT]
                                : rdone_q);

   // Control register, bit 6 has no storage
   always_ff @(posedge clk) begin
      if (rst) begin
         fmt_q   <= asp_pkg::CTRL_RESET[asp_pkg::FMT_BIT];
         check_q <= asp_pkg::CTRL_RESET[asp_pkg::CHECK_BIT];
         rxen_q  <= asp_pkg::CTRL_RESET[asp_pkg::RXEN_BIT];
         tx9_q   <= asp_pkg::CTRL_RESET[asp_pkg::TX9_BIT];
      end else if (wr_ctrl) begin
         fmt_q   <= reg_wdata[asp_pkg::FMT_BIT];
         check_q <= reg_wdata[asp_pkg::CHECK_BIT];
         rxen_q  <= reg_wdata[asp_pkg::RXEN_BIT];
         tx9_q   <= reg_wdata[asp_pkg::TX9_BIT];
      end
   end

   // Flags, ninth receive field and receive latch
   always_ff @(posedge clk) begin
      if (rst) begin
         tdone_q    <= asp_pkg::CTRL_RESET[asp_pkg::TDONE_BIT];
         rdone_q    <= asp_pkg::CTRL_RESET[asp_pkg::RDONE_BIT];
         rx9_q      <= asp_pkg::CTRL_RESET[asp_pkg::RX9_BIT];
         rx_latch_q <= asp_pkg::DATA_RESET;
      end else begin
         tdone_q <= tdone_d;
         rdone_q <= rdone_d;
         // Hardware update wins; otherwise software may write the field
         if (accept) begin
            rx9_q      <= ninth_in;
            rx_latch_q <= rx_bits_q[7:0];
         end else if (wr_ctrl) begin
            rx9_q <= reg_wdata[asp_pkg::RX9_BIT];
         end
      end
   end

   // Read data and interrupt, both registered
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata_q <= 8'h00;
         irq_q       <= 1'b0;
      end else begin
         if (reg_rd) begin
            reg_rdata_q <= rd_mux;
         end
         irq_q <= irq_enable && (tdone_d || rdone_d);
      end
   end

   // Transmit timer, free running auto-reload
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_tmr_q  <= 8'h00;
         tx_half_q <= 1'b0;
      end else if (tick) begin
         tx_tmr_q <= tx_ovf ? baud_reload_byte : tx_tmr_q + 8'h01;
         if (tx_ovf) begin
            tx_half_q <= !tx_half_q;
         end
      end
   end

   // Receive timer copy; reload forced on start so a frame may begin
   // at any time, independent of the transmit timer phase
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_tmr_q   <= 8'h00;
         rx_phase_q <= 1'b0;
      end else if (start_ev) begin
         rx_tmr_q   <= baud_reload_byte;
         rx_phase_q <= 1'b0;
      end else if (tick) begin
         rx_tmr_q <= rx_ovf ? baud_reload_byte : rx_tmr_q + 8'h01;
         if (rx_ovf) begin
            rx_phase_q <= !rx_phase_q;
         end
      end
   end

   // Transmitter: writes while busy are dropped, no collision flag
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_st_q  <= TX_IDLE;
         tx_sh_q  <= '1;
         tx_cnt_q <= 4'h0;
         txd_q    <= 1'b1;
      end else begin
         unique case (tx_st_q)
            TX_IDLE: begin
               if (tx_start) begin
                  // Stop, ninth (or stop again), data LSB first, start
                  tx_sh_q  <= {1'b1, fmt_q ? tx9_q : 1'b1,
                               reg_wdata, 1'b0};
                  tx_cnt_q <= fmt_q ? asp_pkg::FRAME_BITS9
                                    : asp_pkg::FRAME_BITS8;
                  tx_st_q  <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (tx_baud) begin
                  if (tx_cnt_q == 4'h0) begin
                     tx_st_q <= TX_IDLE; // Stop bit time complete
                  end else begin
                     txd_q    <= tx_sh_q[0];
                     tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                     tx_cnt_q <= tx_cnt_q - 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // Receiver; clearing the enable abandons a frame in progress
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_st_q    <= RX_IDLE;
         rx_bits_q  <= 9'h000;
         rx_idx_q   <= 4'h0;
         rxd_prev_q <= 1'b1;
      end else begin
         rxd_prev_q <= rxd;
         unique case (rx_st_q)
            RX_IDLE: begin
               if (start_ev) begin
                  rx_st_q <= RX_START;
               end
            end
            RX_START: begin
               if (!rxen_q) begin
                  rx_st_q <= RX_IDLE;
               end else if (rx_samp) begin
                  // A high start at mid-bit is a glitch, not a frame
                  rx_st_q  <= rxd ? RX_IDLE : RX_DATA;
                  rx_idx_q <= 4'h0;
               end
            end
            RX_DATA: begin
               if (!rxen_q || at_last) begin
                  rx_st_q <= RX_IDLE;
               end else if (rx_samp) begin
                  rx_bits_q[rx_idx_q[3:0] == 4'h8 ? 8 : rx_idx_q[2:0]]
                           <= rxd;
                  rx_idx_q <= rx_idx_q + 4'h1;
               end
            end
         endcase
      end
   end

   // Outputs straight from flops
   assign reg_rdata        = reg_rdata_q;
   assign irq              = irq_q;
   assign link.dev_to_peer = txd_q;
endmodule : asp_device

// [asp_peer.sv]
// Remote serial partner: plain UART with 8 or 9-bit frames
module asp_peer #(
   parameter int BIT_CYCLES = 32
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Frame format, high for nine-bit frames
   input  wire logic       nine_bit_mode,
   // Send side
   input  wire logic       send_valid,
   input  wire logic [7:0] send_data,
   input  wire logic       send_ninth,
   output logic            send_ready,
   // Receive side
   output logic            recv_valid,
   output logic      [7:0] recv_data,
   output logic            recv_ninth,
   output logic            recv_stop,
   // Serial link
   asp_link_if.peer        link
);
   typedef enum logic [1:0] {PT_IDLE = 2'b01, PT_SEND = 2'b10} asp_pt_type;
   typedef enum logic [1:0] {PR_IDLE = 2'b01, PR_BITS = 2'b10} asp_pr_type;
   localparam logic [15:0] FULL_BIT = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2 - 1);

   asp_pt_type  tx_st_q;
   logic [10:0] tx_sh_q;
   logic [3:0]  tx_cnt_q;
   logic [15:0] tx_tmr_q;
   logic        txd_q;
   asp_pr_type  rx_st_q;
   logic [15:0] rx_tmr_q;
   logic [3:0]  rx_idx_q;
   logic [10:0] rx_sh_q;
   logic        rxd_prev_q, valid_q, ninth_q, stop_q;
   logic [7:0]  data_q;

   wire [3:0] frame_bits = nine_bit_mode ? asp_pkg::FRAME_BITS9
                                         : asp_pkg::FRAME_BITS8;
   wire       rxd        = link.dev_to_peer;
   wire       rx_tick    = (rx_st_q == PR_BITS) && (rx_tmr_q == 16'h0000);

   // Transmitter; the ninth bit marks addresses when acting as master
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_st_q  <= PT_IDLE;
         tx_sh_q  <= '1;
         tx_cnt_q <= 4'h0;
         tx_tmr_q <= 16'h0000;
         txd_q    <= 1'b1;
      end else begin
         unique case (tx_st_q)
            PT_IDLE: begin
               if (send_valid) begin
                  tx_sh_q  <= {1'b1, nine_bit_mode ? send_ninth : 1'b1,
                               send_data, 1'b0};
                  tx_cnt_q <= frame_bits;
                  tx_tmr_q <= 16'h0000;
                  tx_st_q  <= PT_SEND;
               end
            end
            PT_SEND: begin
               if (tx_tmr_q != 16'h0000) begin
                  tx_tmr_q <= tx_tmr_q - 16'h0001;
               end else if (tx_cnt_q == 4'h0) begin
                  tx_st_q <= PT_IDLE;
               end else begin
                  txd_q    <= tx_sh_q[0];
                  tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                  tx_cnt_q <= tx_cnt_q - 4'h1;
                  tx_tmr_q <= FULL_BIT;
               end
            end
         endcase
      end
   end

   // Receiver: falling edge starts, samples at mid-bit
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_st_q    <= PR_IDLE;
         rx_tmr_q   <= 16'h0000;
         rx_idx_q   <= 4'h0;
         rx_sh_q    <= 11'h000;
         rxd_prev_q <= 1'b1;
         valid_q    <= 1'b0;
         data_q     <= 8'h00;
         ninth_q    <= 1'b0;
         stop_q     <= 1'b0;
      end else begin
         rxd_prev_q <= rxd;
         valid_q    <= 1'b0;
         unique case (rx_st_q)
            PR_IDLE: begin
               if (rxd_prev_q && !rxd) begin
                  rx_st_q  <= PR_BITS;
                  rx_tmr_q <= HALF_BIT;
                  rx_idx_q <= 4'h0;
               end
            end
            PR_BITS: begin
               if (!rx_tick) begin
                  rx_tmr_q <= rx_tmr_q - 16'h0001;
               end else if (rx_idx_q == 4'h0 && rxd) begin
                  rx_st_q <= PR_IDLE; // False start
               end else if (rx_idx_q == frame_bits - 4'h1) begin
                  // Last sample is the stop bit
                  rx_st_q <= PR_IDLE;
                  valid_q <= 1'b1;
                  data_q  <= rx_sh_q[8:1];
                  ninth_q <= nine_bit_mode ? rx_sh_q[9] : rxd;
                  stop_q  <= rxd;
               end else begin
                  rx_sh_q[rx_idx_q] <= rxd;
                  rx_idx_q <= rx_idx_q + 4'h1;
                  rx_tmr_q <= FULL_BIT;
               end
            end
         endcase
      end
   end

   // Outputs straight from flops
   assign send_ready       = tx_st_q[0]; // Idle bit of the one-hot state
   assign recv_valid       = valid_q;
   assign recv_data        = data_q;
   assign recv_ninth       = ninth_q;
   assign recv_stop        = stop_q;
   assign link.peer_to_dev = txd_q;
endmodule : asp_peer

// [asp_link_checker.sv]
// Wire-level checker for both directions of the serial link
module asp_link_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial link lines
   input wire logic dev_to_peer,
   input wire logic peer_to_dev
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [9:0] tx_run_q;
   logic [9:0] rx_run_q;
   logic       tx_prev_q;
   logic       rx_prev_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Run length of the current level; saturates so a long idle never wraps
   always_ff @(posedge clk) begin
      tx_prev_q <= dev_to_peer;
      rx_prev_q <= peer_to_dev;
      if (rst) begin
         tx_run_q <= 10'h3FF;
         rx_run_q <= 10'h3FF;
      end else begin
         tx_run_q <= (dev_to_peer != tx_prev_q) ? 10'h001
                     : tx_run_q + {9'h000, ~&tx_run_q};
         rx_run_q <= (peer_to_dev != rx_prev_q) ? 10'h001
                     : rx_run_q + {9'h000, ~&rx_run_q};
      end
   end

   // Lines idle high once reset is released
   a_tx_idle_reset: assert property ($fell(rst) |-> dev_to_peer)
      else $error("transmit line not idle after reset");
   a_rx_idle_reset: assert property ($fell(rst) |-> peer_to_dev)
      else $error("receive line not idle after reset");
   // Every low run is a whole number of 32-cycle bits
   a_tx_bit_width: assert property (
      $rose(dev_to_peer) |-> tx_run_q[4:0] == 5'h00)
      else $error("transmit low run not a whole bit count");
   a_rx_bit_width: assert property (
      $rose(peer_to_dev) |-> rx_run_q[4:0] == 5'h00)
      else $error("receive low run not a whole bit count");
   // Start plus nine zero bits is the longest legal low run
   a_tx_low_max: assert property (
      !dev_to_peer && !tx_prev_q |-> tx_run_q < 10'h140)
      else $error("transmit line low for too long");
   a_rx_low_max: assert property (
      !peer_to_dev && !rx_prev_q |-> rx_run_q < 10'h140)
      else $error("receive line low for too long");
   // A start or data low follows at least one full high bit
   a_tx_stop_high: assert property (
      $fell(dev_to_peer) |-> tx_run_q >= 10'h020)
      else $error("transmit high run shorter than one bit");
   a_rx_stop_high: assert property (
      $fell(peer_to_dev) |-> rx_run_q >= 10'h020)
      else $error("receive high run shorter than one bit");
endmodule : asp_link_checker

// [testbench.sv]
// Testbench joining the serial port and a remote partner over one link
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk        = 1'h0;
   logic        rst        = 1'h1;
   logic [7:0]  reg_addr   = 8'h00;
   logic        reg_wr     = 1'h0;
   logic [7:0]  reg_wdata  = 8'h00;
   logic        reg_rd     = 1'h0;
   logic        irq_enable = 1'h1;
   logic        nine       = 1'h0;
   logic        send_valid = 1'h0;
   logic [7:0]  send_data  = 8'h00;
   logic        send_ninth = 1'h0;
   logic [7:0]  reg_rdata, recv_data, ctl, v, last_rx;
   logic        irq, send_ready, recv_valid, recv_ninth, recv_stop;
   logic [19:0] r;
   int          i, j, errors = 0, checked = 0, cycles = 0, frames = 0;
   // Expected control readback, then format, check enable, ninth bit,
   // direction (1 = into port) and byte
   logic [19:0] rows [10] = '{20'h520A5, 20'hD283C, 20'hDAAC3, 20'h520FF,
                             20'hD2800, 20'h7555A, 20'hFDF81, 20'hF0D7E,
                             20'hD1900, 20'h551FF};

   asp_link_if u_asp_link_if ();
   // Reload F0 with a tick every clock gives a 32-cycle bit
   asp_device u_asp_device (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .baud_timer_input_clock(1'h1), .baud_timer_run(1'h1),
      .baud_reload_byte(8'hF0), .irq_enable(irq_enable), .irq(irq),
      .link(u_asp_link_if));
   asp_peer #(.BIT_CYCLES(32)) u_asp_peer (
      .clk(clk), .rst(rst), .nine_bit_mode(nine), .send_valid(send_valid),
      .send_data(send_data), .send_ninth(send_ninth),
      .send_ready(send_ready), .recv_valid(recv_valid),
      .recv_data(recv_data), .recv_ninth(recv_ninth), .recv_stop(recv_stop),
      .link(u_asp_link_if));
   asp_link_checker u_asp_link_checker (
      .clk(clk), .rst(rst), .dev_to_peer(u_asp_link_if.dev_to_peer),
      .peer_to_dev(u_asp_link_if.peer_to_dev));

   always #2 clk = ~clk;

   // Frames the partner has taken in, counted where the pulse is settled
   always @(negedge clk) begin
      if (recv_valid) begin
         frames++;
      end
   end

   task automatic end_sim;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   // Hang guard; a full run needs well under 10000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_sim();
      end
   end

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'h1;
      @(negedge clk);
      reg_wr    = 1'h0;
   endtask : wr

   // Read data is registered, so it is taken one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'h1;
      @(negedge clk);
      reg_rd   = 1'h0;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd

   // Partner is idle whenever this is called, so one cycle of valid is taken
   task automatic psend(input logic [7:0] d, input logic n9);
      @(negedge clk);
      cmp({7'h00, send_ready}, 8'h01);
      send_data  = d;
      send_ninth = n9;
      send_valid = 1'h1;
      @(negedge clk);
      send_valid = 1'h0;
   endtask : psend

   // Sample a device frame on the wire at mid-bit, LSB first
   task automatic wire_frame(input logic [10:0] bits, input int n);
      for (i = 0; i < 500 && u_asp_link_if.dev_to_peer !== 1'h0; i++)
         @(negedge clk);
      repeat (16) @(negedge clk);
      for (j = 0; j < n; j++) begin
         cmp({7'h00, u_asp_link_if.dev_to_peer}, {7'h00, bits[j]});
         // Done flag, seen through the interrupt, rises at the stop bit
         if (j >= n - 2) begin
            cmp({7'h00, irq}, {7'h00, irq_enable & (j == n - 1)});
         end
         repeat (32) @(negedge clk);
      end
   endtask : wire_frame

   initial begin
      repeat (2) @(negedge clk);
      rst = 1'h0;
      // Table of frames in both directions and both formats
      foreach (rows[k]) begin
         r    = rows[k];
         nine = r[11];
         ctl  = {r[11], 1'h1, r[10], 1'h1, r[9], 3'h0};
         wr(8'h98, ctl);
         if (!r[8]) begin
            wr(8'h99, r[7:0]);
            wire_frame(r[11] ? {1'h1, r[9], r[7:0], 1'h0}
                             : {2'h3, r[7:0], 1'h0}, r[11] ? 11 : 10);
            cmp(recv_data, r[7:0]);
            cmp({7'h00, recv_stop}, 8'h01);
            cmp({7'h00, recv_ninth}, {7'h00, r[11] ? r[9] : 1'h1});
         end else begin
            psend(r[7:0], r[9]);
            for (i = 0; i < 420 && irq !== 1'h1; i++)
               @(negedge clk);
            if (r[12]) last_rx = r[7:0];
         end
         cmp({7'h00, irq}, {7'h00, r[13] | r[12]});
         rd(8'h98, v);
         cmp(v, r[19:12]);
         rd(8'h99, v);
         if (r[8]) cmp(v, last_rx);
         repeat (40) @(negedge clk);
      end
      // Overrun: second frame arrives with the done flag still set
      wr(8'h98, 8'h10);
      psend(8'h11, 1'h0);
      repeat (400) @(negedge clk);
      psend(8'h22, 1'h0);
      repeat (400) @(negedge clk);
      rd(8'h99, v);
      cmp(v, 8'h11);
      rd(8'h98, v);
      cmp(v, 8'h55);
      // Receiver off: frame is ignored
      wr(8'h98, 8'h00);
      psend(8'h33, 1'h0);
      repeat (400) @(negedge clk);
      rd(8'h98, v);
      cmp(v, 8'h40);
      rd(8'h99, v);
      cmp(v, 8'h11);
      // Interrupt gated off while the done flag still sets
      irq_enable = 1'h0;
      nine = 1'h0;
      wr(8'h99, 8'h5A);
      wire_frame({2'h3, 8'h5A, 1'h0}, 10);
      cmp({7'h00, irq}, 8'h00);
      // Five table frames and this one reached the partner
      cmp(8'(frames), 8'h06);
      rd(8'h98, v);
      cmp(v, 8'h42);
      rd(8'h9A, v);
      cmp(v, 8'h00);
      // Second reset, then the unused bit ignores writes
      rst = 1'h1;
      repeat (2) @(negedge clk);
      rst = 1'h0;
      rd(8'h98, v);
      cmp(v, 8'h40);
      rd(8'h99, v);
      cmp(v, 8'h00);
      wr(8'h98, 8'h00);
      rd(8'h98, v);
      cmp(v, 8'h40);
      wr(8'h98, 8'hBF);
      rd(8'h98, v);
      cmp(v, 8'hFF);
      end_sim();
   end
endmodule : testbench
